// ---- rtl/nfr_regs.vh ----
/*
  Constants of the fault reporter: timing, flag positions, state codes.
  Assumes inclusion by every design file of the fault reporter.
*/
`ifndef NFR_REGS_VH
`define NFR_REGS_VH

// ***********************************************
// Timing
// ***********************************************
`define NFR_CLK_HZ          25000000
`define NFR_PULSE_US        50
`define NFR_PULSE_CYC       ((`NFR_CLK_HZ / 1000000) * `NFR_PULSE_US)

// ***********************************************
// Status register bit positions
// ***********************************************
`define NFR_ST_LOW_SUPPLY   0
`define NFR_ST_SUPPLY_UV    1
`define NFR_ST_REFERENCE    2
`define NFR_ST_THERMAL_WARN 3
`define NFR_ST_OVERTEMP     4
`define NFR_ST_REG_OV       5
`define NFR_ST_POWER_FAULT  6
`define NFR_ST_ERROR        7
`define NFR_ST_OUTPUT       8
`define NFR_ST_CHECKSUM     9
`define NFR_ST_WIDTH        10

// ***********************************************
// Device states
// ***********************************************
`define NFR_STATE_NORMAL    2'h0
`define NFR_STATE_POR       2'h1
`define NFR_STATE_STARTUP   2'h2

`endif

// ---- rtl/nfr_pulse_timer.v ----
/*
  One-shot low pulse timer for the fault pin.
  Assumes a single clock, synchronous active-low reset, one-cycle triggers.
*/
`timescale 1ns/1ns
`include "nfr_regs.vh"

module nfr_pulse_timer #(
  parameter CYCLES = `NFR_PULSE_CYC,
  parameter CW     = 12
) (
  // Clock and reset
  input  wire i_clk_sys,
  input  wire i_rst_n,
  // Trigger and output
  input  wire i_trigger,
  output reg  o_active
);

  reg [CW-1:0] count;

  // A new trigger while running restarts the full width; pulses merge.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      count    <= {CW{1'b0}};
      o_active <= 1'b0;
    end else if (i_trigger) begin
      count    <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}; // R17
      o_active <= 1'b1;
    end else if (count != {CW{1'b0}}) begin
      count    <= count - {{(CW-1){1'b0}}, 1'b1};
    end else begin
      o_active <= 1'b0;
    end
  end

endmodule

// ---- rtl/nfr_fault_reporter.v ----
/*
  Fault aggregation and reporting for the normal operating state: flags,
  masks, fault pin pulse and constant-low drive, output shutdown, power state.
  Assumes analog detections arrive as levels from other clock domains and are
  synchronised here; software reaches registers over a plain strobe port.
*/
`timescale 1ns/1ns
`include "nfr_regs.vh"

// Functional notes
// R1: Masked LED faults set only the channel flag; unmasked add summary, error, pulse.
// R2: Battery or regulator undervoltage enters power reset, sets flags, holds pin low.
// R3: Regulator overvoltage sets its flag and error, holds pin low while present.
// R4: Low supply warning sets its flag; unmasked also error and one pulse.
// R5: Supply undervoltage turns outputs off, sets flags; unmasked holds pin low.
// R6: Reference fault keeps outputs running, sets flag; unmasked holds pin low.
// R7: Thermal warning sets flag only; unmasked also error and one pulse.
// R8: First overtemperature turns outputs off, sets both thermal flags; unmasked holds pin.
// R9: Second overtemperature kills regulator, sets power flags, holds pin, needs power clear.
// R10: Open detection only with channel enabled, diagnostics on, pulse long enough.
// R11: Open fault needs low headroom with supply above low threshold.
// R12: Detections come from comparators, or from the ADC when auto scan is set. Low supply is always taken from the ADC input.
// R13: Latched fault flags stay set until clear_error_flags is written.
// R14: Controller clears power flags; startup only once all rails are good.
// R15: The clear_error_flags bit returns to zero by itself.
// R16: Masks gate only summary, error and pin; specific flags still set. Masks also gate the interrupt events.
// R17: Pulse is timed by a cycle counter; constant-low wins over the pulse.
// R18: One pulse per rising edge of a new unmasked pulse-type fault.
module nfr_fault_reporter #(
  parameter CH = 12
) (
  // Clock and reset
  input  wire          i_clk_sys,
  input  wire          i_rst_n,
  // Comparator detections
  input  wire          i_cmp_bat_uv,
  input  wire          i_cmp_reg_uv,
  input  wire          i_cmp_reg_ov,
  input  wire          i_cmp_supply_uv,
  input  wire          i_cmp_reference,
  input  wire          i_cmp_thermal_warn,
  input  wire          i_cmp_overtemp1,
  input  wire          i_cmp_overtemp2,
  input  wire [CH-1:0] i_cmp_open,
  // ADC detections
  input  wire          i_adc_low_supply,
  input  wire          i_adc_supply_uv,
  input  wire          i_adc_reference,
  input  wire          i_adc_thermal_warn,
  input  wire          i_adc_overtemp1,
  input  wire [CH-1:0] i_adc_open,
  input  wire          i_supply_above_low,
  // Per-channel diagnostics, checksum event and rails status from the same clock
  input  wire [CH-1:0] i_pwm_long_enough,
  input  wire [CH-1:0] i_short_event,
  input  wire [CH-1:0] i_sls_event,
  input  wire          i_checksum_event,
  input  wire          i_rails_good,
  // Configuration
  input  wire [CH-1:0] i_channel_enable,
  input  wire [CH-1:0] i_channel_diag_enable,
  input  wire          i_auto_scan_enable,
  input  wire          i_open_fault_mask,
  input  wire          i_short_fault_mask,
  input  wire          i_single_led_short_mask,
  input  wire          i_low_supply_mask,
  input  wire          i_supply_undervoltage_mask,
  input  wire          i_reference_fault_mask,
  input  wire          i_thermal_warning_mask,
  input  wire          i_overtemp_mask,
  input  wire          i_memory_checksum_mask,
  // Register port
  input  wire [3:0]    i_addr,
  input  wire [15:0]   i_wdata,
  input  wire          i_wr,
  input  wire          i_rd,
  output reg  [15:0]   o_rdata,
  // Fault and power outputs
  output reg           o_fault_out_pin_oe,
  output reg           o_outputs_off,
  output reg           o_regulator_off,
  output reg  [1:0]    o_state,
  output reg           o_irq
);

  // ***********************************************
  // Register map
  // ***********************************************
  localparam [3:0] A_STATUS   = 4'h0;
  localparam [3:0] A_OPEN     = 4'h1;
  localparam [3:0] A_SHORT    = 4'h2;
  localparam [3:0] A_SLS      = 4'h3;
  localparam [3:0] A_CONTROL  = 4'h4;
  localparam [3:0] A_IRQ_STAT = 4'h5;
  localparam [3:0] A_IRQ_MASK = 4'h6;
  localparam [3:0] A_STATE    = 4'h7;
  localparam       CTL_CLEAR_ERROR_FLAGS = 0;
  localparam       CTL_CLEAR_POWER_FAULT = 1;
  localparam       NI          = 4;

  // ***********************************************
  // Input synchronisers
  // ***********************************************
  localparam NS = 14 + 2 * CH;
  wire [NS-1:0] raw_in = {i_cmp_bat_uv, i_cmp_reg_uv, i_cmp_reg_ov, i_cmp_supply_uv, i_cmp_reference,
                          i_cmp_thermal_warn, i_cmp_overtemp1, i_cmp_overtemp2, i_adc_low_supply,
                          i_adc_supply_uv, i_adc_reference, i_adc_thermal_warn, i_adc_overtemp1,
                          i_supply_above_low, i_cmp_open, i_adc_open};
  reg  [NS-1:0] sy1;
  reg  [NS-1:0] sy2;
  reg  [NS-1:0] sy3;
  reg  [NS-1:0] clean;

  // A level is accepted only once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_sync
      always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          sy1[g]   <= 1'b0;
          sy2[g]   <= 1'b0;
          sy3[g]   <= 1'b0;
          clean[g] <= 1'b0;
        end else begin
          sy1[g] <= raw_in[g];
          sy2[g] <= sy1[g];
          sy3[g] <= sy2[g];
          if (sy2[g] == sy3[g]) begin
            clean[g] <= sy3[g];
          end
        end
      end
    end
  endgenerate

  wire [CH-1:0] s_adc_open   = clean[CH-1:0];
  wire [CH-1:0] s_cmp_open   = clean[2*CH-1:CH];
  wire          s_above_low  = clean[2*CH];
  wire          s_adc_ot1    = clean[2*CH+1];
  wire          s_adc_tw     = clean[2*CH+2];
  wire          s_adc_ref    = clean[2*CH+3];
  wire          s_adc_uv     = clean[2*CH+4];
  wire          s_low_supply = clean[2*CH+5];
  wire          s_ot2        = clean[2*CH+6];
  wire          s_cmp_ot1    = clean[2*CH+7];
  wire          s_cmp_tw     = clean[2*CH+8];
  wire          s_cmp_ref    = clean[2*CH+9];
  wire          s_cmp_uv     = clean[2*CH+10];
  wire          s_reg_ov     = clean[2*CH+11];
  wire          s_reg_uv     = clean[2*CH+12];
  wire          s_bat_uv     = clean[2*CH+13];

  // ***********************************************
  // Detection sources
  // ***********************************************
  function pick;
    input sel_adc;
    input cmp_v;
    input adc_v;
    begin
      pick = sel_adc ? adc_v : cmp_v;
    end
  endfunction

  wire          det_uv  = pick(i_auto_scan_enable, s_cmp_uv, s_adc_uv);   // R12
  wire          det_ref = pick(i_auto_scan_enable, s_cmp_ref, s_adc_ref); // R12
  wire          det_tw  = pick(i_auto_scan_enable, s_cmp_tw, s_adc_tw);   // R12
  wire          det_ot1 = pick(i_auto_scan_enable, s_cmp_ot1, s_adc_ot1); // R12
  wire          det_por = s_bat_uv | s_reg_uv | s_ot2;
  wire [CH-1:0] open_src  = i_auto_scan_enable ? s_adc_open : s_cmp_open; // R12
  wire [CH-1:0] det_open  = open_src & i_channel_enable & i_channel_diag_enable
                            & i_pwm_long_enough & {CH{s_above_low}};      // R10 R11
  wire [CH-1:0] diag_ok   = i_channel_enable & i_channel_diag_enable;
  wire [CH-1:0] det_short = i_short_event & diag_ok & i_pwm_long_enough;
  wire [CH-1:0] det_sls   = i_sls_event & diag_ok;

  // ***********************************************
  // Flags and state
  // ***********************************************
  reg  [`NFR_ST_WIDTH-1:0] status;
  reg  [CH-1:0]            open_flag;
  reg  [CH-1:0]            short_flag;
  reg  [CH-1:0]            sls_flag;
  reg  [1:0]               state;
  reg  [1:0]               control;
  reg  [NI-1:0]            irq_stat;
  reg  [NI-1:0]            irq_mask;
  reg                      prev_tw;
  reg                      prev_low;
  reg                      prev_chk;
  reg  [CH-1:0]            prev_open;
  reg  [CH-1:0]            prev_short;
  reg  [CH-1:0]            prev_sls;

  wire clear_error_flags = i_wr && (i_addr == A_CONTROL) && i_wdata[CTL_CLEAR_ERROR_FLAGS]; // R13
  wire clear_power_fault = i_wr && (i_addr == A_CONTROL) && i_wdata[CTL_CLEAR_POWER_FAULT]; // R14

  wire [CH-1:0] new_open  = det_open & ~prev_open;
  wire [CH-1:0] new_short = det_short & ~prev_short;
  wire [CH-1:0] new_sls   = det_sls & ~prev_sls;
  wire rise_tw  = det_tw & ~prev_tw;
  wire rise_low = s_low_supply & ~prev_low;
  wire rise_chk = i_checksum_event & ~prev_chk;

  wire led_rpt = (|new_open & ~i_open_fault_mask) | (|new_short & ~i_short_fault_mask)
                 | (|new_sls & ~i_single_led_short_mask);                              // R1 R16
  wire pulse_req = led_rpt | (rise_tw & ~i_thermal_warning_mask)
                   | (rise_low & ~i_low_supply_mask) | (rise_chk & ~i_memory_checksum_mask); // R18
  wire uv_rpt  = det_uv & ~i_supply_undervoltage_mask;
  wire ref_rpt = det_ref & ~i_reference_fault_mask;
  wire ot_rpt  = det_ot1 & ~i_overtemp_mask;
  wire hold_low = (state == `NFR_STATE_POR) | s_reg_ov | uv_rpt | ref_rpt | ot_rpt;   // R2 R3 R5 R6 R8
  wire err_set  = pulse_req | hold_low;

  wire [`NFR_ST_WIDTH-1:0] set_bits;
  assign set_bits[`NFR_ST_LOW_SUPPLY]   = s_low_supply | det_uv;  // R4 R5
  assign set_bits[`NFR_ST_SUPPLY_UV]    = det_uv;                 // R5
  assign set_bits[`NFR_ST_REFERENCE]    = det_ref;                // R6
  assign set_bits[`NFR_ST_THERMAL_WARN] = det_tw | det_ot1;       // R7 R8
  assign set_bits[`NFR_ST_OVERTEMP]     = det_ot1;                // R8
  assign set_bits[`NFR_ST_REG_OV]       = s_reg_ov;               // R3
  assign set_bits[`NFR_ST_POWER_FAULT]  = det_por;                // R2 R9
  assign set_bits[`NFR_ST_ERROR]        = err_set;
  assign set_bits[`NFR_ST_OUTPUT]       = led_rpt;                // R1
  assign set_bits[`NFR_ST_CHECKSUM]     = i_checksum_event;

  // Power flags survive the error clear; only the power clear drops them.
  wire [`NFR_ST_WIDTH-1:0] err_clr_bits = {`NFR_ST_WIDTH{clear_error_flags}}
                             & ~(10'h1 << `NFR_ST_POWER_FAULT)
                             & ~((10'h1 << `NFR_ST_ERROR) & {`NFR_ST_WIDTH{status[`NFR_ST_POWER_FAULT]}});
  wire [`NFR_ST_WIDTH-1:0] por_clr_bits = {`NFR_ST_WIDTH{clear_power_fault}}
                             & ((10'h1 << `NFR_ST_POWER_FAULT) | (10'h1 << `NFR_ST_ERROR));
  wire [`NFR_ST_WIDTH-1:0] next_status = (status & ~(err_clr_bits | por_clr_bits)) | set_bits; // R13 R9

  reg           prev_por_ev;
  reg           prev_hold;
  wire [NI-1:0] ev = {det_por & ~prev_por_ev, |(det_open | det_short | det_sls) & led_rpt,
                      hold_low & ~prev_hold, pulse_req};

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      status      <= {`NFR_ST_WIDTH{1'b0}};
      open_flag   <= {CH{1'b0}};
      short_flag  <= {CH{1'b0}};
      sls_flag    <= {CH{1'b0}};
      state       <= `NFR_STATE_NORMAL;
      control     <= 2'h0;
      irq_stat    <= {NI{1'b0}};
      irq_mask    <= {NI{1'b0}};
      prev_tw     <= 1'b0;
      prev_low    <= 1'b0;
      prev_chk    <= 1'b0;
      prev_open   <= {CH{1'b0}};
      prev_short  <= {CH{1'b0}};
      prev_sls    <= {CH{1'b0}};
      prev_por_ev <= 1'b0;
      prev_hold   <= 1'b0;
    end else begin
      status     <= next_status;
      open_flag  <= (open_flag & ~{CH{clear_error_flags}}) | det_open;    // R11 R13 R16
      short_flag <= (short_flag & ~{CH{clear_error_flags}}) | det_short;  // R1
      sls_flag   <= (sls_flag & ~{CH{clear_error_flags}}) | det_sls;      // R1
      prev_tw     <= det_tw;
      prev_low    <= s_low_supply;
      prev_chk    <= i_checksum_event;
      prev_open   <= det_open;
      prev_short  <= det_short;
      prev_sls    <= det_sls;
      prev_por_ev <= det_por;
      prev_hold   <= hold_low;
      // Command bits are write-only pulses and read back as zero.
      control <= 2'h0; // R15
      irq_stat <= (irq_stat & ~((i_wr && i_addr == A_IRQ_STAT) ? i_wdata[NI-1:0] : {NI{1'b0}})) | ev;
      if (i_wr && i_addr == A_IRQ_MASK) begin
        irq_mask <= i_wdata[NI-1:0];
      end
      case (state)
        `NFR_STATE_NORMAL: begin
          if (det_por) begin
            state <= `NFR_STATE_POR; // R2 R9
          end
        end
        `NFR_STATE_POR: begin
          if (!det_por && i_rails_good) begin
            state <= `NFR_STATE_STARTUP; // R14
          end
        end
        `NFR_STATE_STARTUP: begin
          if (det_por) begin
            state <= `NFR_STATE_POR;
          end else begin
            state <= `NFR_STATE_NORMAL;
          end
        end
        default: begin
          state <= `NFR_STATE_POR;
        end
      endcase
    end
  end

  // ***********************************************
  // Fault pin
  // ***********************************************
  wire pulse_active;

  nfr_pulse_timer #(
    .CYCLES (`NFR_PULSE_CYC),
    .CW     (12)
  ) u_pulse (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_trigger (pulse_req),
    .o_active  (pulse_active)
  );

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_fault_out_pin_oe <= 1'b0;
      o_outputs_off      <= 1'b0;
      o_regulator_off    <= 1'b0;
      o_state            <= `NFR_STATE_NORMAL;
      o_irq              <= 1'b0;
    end else begin
      // Constant-low conditions override the timed pulse.
      o_fault_out_pin_oe <= hold_low ? 1'b1 : pulse_active;                        // R17 R1 R4 R7
      o_outputs_off      <= det_uv | det_ot1 | (state != `NFR_STATE_NORMAL);       // R5 R8
      o_regulator_off    <= s_ot2;                                                  // R9
      o_state            <= state;
      o_irq              <= |(irq_stat & irq_mask);
    end
  end

  // ***********************************************
  // Register read
  // ***********************************************
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        A_STATUS:   o_rdata <= {{(16-`NFR_ST_WIDTH){1'b0}}, status};
        A_OPEN:     o_rdata <= {{(16-CH){1'b0}}, open_flag};
        A_SHORT:    o_rdata <= {{(16-CH){1'b0}}, short_flag};
        A_SLS:      o_rdata <= {{(16-CH){1'b0}}, sls_flag};
        A_CONTROL:  o_rdata <= {14'h0000, control};
        A_IRQ_STAT: o_rdata <= {{(16-NI){1'b0}}, irq_stat};
        A_IRQ_MASK: o_rdata <= {{(16-NI){1'b0}}, irq_mask};
        A_STATE:    o_rdata <= {14'h0000, state};
        default:    o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// ---- bench/nfr_master_model.sv ----
/*
  Master controller model: watches the open-drain fault pin.
  Assumes a pull-up on the pin and the design's single clock.
*/
`timescale 1ns/1ns
module nfr_master_model (
  // Clock and pin enable
  input  wire         i_clk_sys,
  input  wire         i_fault_oe,
  // Observations
  output logic [7:0]  o_pulses,
  output logic [15:0] o_width
);
  logic        pin;
  logic [15:0] run;
  // The pull-up wins whenever the device lets go of the pin.
  assign pin = i_fault_oe ? 1'b0 : 1'b1;
  initial begin
    o_pulses = 8'h00;
    o_width  = 16'h0000;
    run      = 16'h0000;
  end
  // A low period is counted only once it ends, so a held pin reads as a pulse only after it is released.
  always @(posedge i_clk_sys) begin
    if (!pin) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      o_pulses <= o_pulses + 8'h01;
      o_width  <= run;
      run      <= 16'h0000;
    end
  end
endmodule

// ---- bench/nfr_fault_reporter_assertions.sv ----
/*
  Port checker of the fault reporter.
  Assumes it is bound into nfr_fault_reporter with one clock domain.
*/
`timescale 1ns/1ns
module nfr_fault_reporter_assertions #(
  parameter CH = 12
) (
  input wire          i_clk_sys,
  input wire          i_rst_n,
  input wire          i_cmp_bat_uv,
  input wire          i_cmp_reg_ov,
  input wire          i_cmp_supply_uv,
  input wire          i_cmp_reference,
  input wire          i_cmp_overtemp1,
  input wire          i_adc_supply_uv,
  input wire          i_auto_scan_enable,
  input wire [CH-1:0] i_short_event,
  input wire [CH-1:0] i_channel_enable,
  input wire [CH-1:0] i_channel_diag_enable,
  input wire [CH-1:0] i_pwm_long_enough,
  input wire          i_short_fault_mask,
  input wire          i_reference_fault_mask,
  input wire [3:0]    i_addr,
  input wire          i_rd,
  input wire [15:0]   o_rdata,
  input wire          o_fault_out_pin_oe,
  input wire          o_outputs_off,
  input wire [1:0]    o_state
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Async detections pass a synchroniser, so six steady cycles are allowed.
  property p_short_pulse;
    $rose(|(i_short_event & i_channel_enable & i_channel_diag_enable & i_pwm_long_enough))
      && !i_short_fault_mask && o_state == 2'h0 |-> ##2 o_fault_out_pin_oe;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short fault gave no pin pulse");
  property p_ctrl_zero;
    i_rd && i_addr == 4'h4 |=> o_rdata == 16'h0000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control bits did not read zero");
  property p_bat_uv;
    i_cmp_bat_uv [*6] |=> o_state == 2'h1 && o_fault_out_pin_oe;
  endproperty
  a_bat_uv: assert property (p_bat_uv) else $error("undervoltage did not enter power reset");
  property p_reg_ov;
    i_cmp_reg_ov [*6] |=> o_fault_out_pin_oe;
  endproperty
  a_reg_ov: assert property (p_reg_ov) else $error("overvoltage did not hold pin");
  property p_uv_off;
    (i_cmp_supply_uv && !i_auto_scan_enable) [*6] |=> o_outputs_off;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("supply undervoltage left outputs on");
  property p_adc_uv;
    (i_adc_supply_uv && i_auto_scan_enable) [*6] |=> o_outputs_off;
  endproperty
  a_adc_uv: assert property (p_adc_uv) else $error("measured undervoltage left outputs on");
  property p_ref_hold;
    (i_cmp_reference && !i_auto_scan_enable && !i_reference_fault_mask) [*6] |=> o_fault_out_pin_oe;
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference fault did not hold pin");
  property p_ot1_off;
    (i_cmp_overtemp1 && !i_auto_scan_enable) [*6] |=> o_outputs_off;
  endproperty
  a_ot1_off: assert property (p_ot1_off) else $error("overtemperature left outputs on");
endmodule
bind nfr_fault_reporter nfr_fault_reporter_assertions #(.CH(CH)) chk_u (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cmp_bat_uv(i_cmp_bat_uv), .i_cmp_reg_ov(i_cmp_reg_ov),
  .i_cmp_supply_uv(i_cmp_supply_uv), .i_cmp_reference(i_cmp_reference), .i_cmp_overtemp1(i_cmp_overtemp1),
  .i_adc_supply_uv(i_adc_supply_uv), .i_auto_scan_enable(i_auto_scan_enable), .i_short_event(i_short_event),
  .i_channel_enable(i_channel_enable), .i_channel_diag_enable(i_channel_diag_enable),
  .i_pwm_long_enough(i_pwm_long_enough), .i_short_fault_mask(i_short_fault_mask),
  .i_reference_fault_mask(i_reference_fault_mask), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_fault_out_pin_oe(o_fault_out_pin_oe), .o_outputs_off(o_outputs_off), .o_state(o_state)
);

// ---- bench/test_normal_state_fault_reporter.sv ----
/*
  Self-checking bench of the fault reporter with the master model.
  Assumes the design header, design and bound checker are compiled.
*/
`timescale 1ns/1ns
`include "nfr_regs.vh"
module test_normal_state_fault_reporter;
  logic        clk = 1'b0, rst_n = 1'b0, above = 1'b1, rails = 1'b1, auto = 1'b0;
  logic        wr_s = 1'b0, rd_s = 1'b0, oe, off, roff, irq;
  logic [7:0]  cmp = 8'h00, mk = 8'h00, pulses;
  logic [4:0]  adc = 5'h00;
  logic [11:0] opn = 12'h000, sht = 12'h000, sls = 12'h000, en = 12'hFFF, dg = 12'hFFF, pw = 12'hFFF;
  logic [3:0]  addr = 4'h0, cfg;
  logic [15:0] wdata = 16'h0000, rdata, width;
  logic [1:0]  st;
  int          failures = 0, num_checks = 0, cyc = 0, ch, k, m, a, i, p0;
  int          hc[4] = '{2, 3, 4, 6};
  int          ha[4] = '{-1, 1, 2, 4};
  int          hm[4] = '{-1, 4, 5, 7};
  logic [15:0] hb[4] = '{16'h0020, 16'h0003, 16'h0004, 16'h0018};
  nfr_fault_reporter #(.CH(12)) dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_cmp_bat_uv(cmp[0]), .i_cmp_reg_uv(cmp[1]), .i_cmp_reg_ov(cmp[2]),
    .i_cmp_supply_uv(cmp[3]), .i_cmp_reference(cmp[4]), .i_cmp_thermal_warn(cmp[5]),
    .i_cmp_overtemp1(cmp[6]), .i_cmp_overtemp2(cmp[7]), .i_cmp_open(opn), .i_adc_low_supply(adc[0]),
    .i_adc_supply_uv(adc[1]), .i_adc_reference(adc[2]), .i_adc_thermal_warn(adc[3]),
    .i_adc_overtemp1(adc[4]), .i_adc_open(opn), .i_supply_above_low(above), .i_pwm_long_enough(pw),
    .i_short_event(sht), .i_sls_event(sls), .i_checksum_event(1'b0), .i_rails_good(rails),
    .i_channel_enable(en), .i_channel_diag_enable(dg), .i_auto_scan_enable(auto),
    .i_open_fault_mask(mk[0]), .i_short_fault_mask(mk[1]), .i_single_led_short_mask(mk[2]),
    .i_low_supply_mask(mk[3]), .i_supply_undervoltage_mask(mk[4]), .i_reference_fault_mask(mk[5]),
    .i_thermal_warning_mask(mk[6]), .i_overtemp_mask(mk[7]), .i_memory_checksum_mask(1'b0),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_fault_out_pin_oe(oe),
    .o_outputs_off(off), .o_regulator_off(roff), .o_state(st), .o_irq(irq)
  );
  nfr_master_model mm_u (.i_clk_sys(clk), .i_fault_oe(oe), .o_pulses(pulses), .o_width(width));
  always #20 clk = ~clk;
  // ***********************************************
  // Checking and bus tasks
  // ***********************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A hung wait is cut short here, well past the roughly 8500 cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk);
    addr  <= ad;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] ad, input logic [15:0] e);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  function automatic logic [15:0] exp_st(input logic [15:0] b, input bit masked);
    return masked ? b : (b | 16'h0080);
  endfunction
  // ***********************************************
  // Tests
  // ***********************************************
  initial begin
    p0 = $urandom(32'h06a8);
    ch = $urandom % 12;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(5);
    chk({10'h000, st, oe, off, roff, irq}, 16'h0000);
    wr(4'hF, 16'($urandom));
    rdc(4'hF, 16'h0000);
    $display("reset test done");
    wr(4'h6, 16'h0001);
    p0 = pulses;
    @(posedge clk);
    sht[ch] <= 1'b1;
    tick(1300);
    chk(16'(pulses), 16'(p0 + 1));
    chk(width, `NFR_PULSE_CYC);
    chk({15'h0000, irq}, 16'h0001);
    rdc(4'h0, exp_st(16'h0100, 1'b0));
    rdc(4'h2, 16'h0001 << ch);
    wr(4'h5, 16'h0001);
    wr(4'h6, 16'h0000);
    sht[ch] <= 1'b0;
    wr(4'h4, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rdc(4'h0, 16'h0000);
    rdc(4'h4, 16'h0000);
    mk[2] <= 1'b1;
    sls[ch] <= 1'b1;
    p0 = pulses;
    tick(20);
    chk(16'(pulses), 16'(p0));
    rdc(4'h0, 16'h0000);
    rdc(4'h3, 16'h0001 << ch);
    mk <= 8'h00;
    sls <= 12'h000;
    wr(4'h4, 16'h0001);
    $display("led fault test done");
    p0 = pulses;
    for (i = 0; i < 5; i++) begin
      cfg = (i < 4) ? ~(4'h8 >> i) : 4'hF;
      @(posedge clk);
      {en[ch], dg[ch], pw[ch], above} <= cfg;
      opn[ch] <= 1'b1;
      tick(12);
      rdc(4'h1, (i == 4) ? (16'h0001 << ch) : 16'h0000);
      opn[ch] <= 1'b0;
      tick(6);
    end
    tick(1260);
    chk(16'(pulses), 16'(p0 + 1));
    wr(4'h4, 16'h0001);
    $display("open test done");
    for (k = 0; k < 2; k++) for (m = 0; m < 2; m++) begin
      p0 = pulses;
      @(posedge clk);
      auto <= 1'b1;
      mk <= m ? (8'h01 << (k ? 6 : 3)) : 8'h00;
      adc <= k ? 5'h08 : 5'h01;
      tick(1300);
      chk(16'(pulses), 16'(p0 + (m ? 0 : 1)));
      rdc(4'h0, exp_st(k ? 16'h0008 : 16'h0001, m[0]));
      adc <= 5'h00;
      tick(6);
      wr(4'h4, 16'h0001);
    end
    chk({15'h0000, irq}, 16'h0000);
    $display("pulse fault test done");
    for (a = 0; a < 2; a++) for (k = 0; k < 4; k++) for (m = 0; m < 2; m++) begin
      @(posedge clk);
      auto <= a[0];
      mk <= (m && hm[k] >= 0) ? (8'h01 << hm[k]) : 8'h00;
      adc <= (a && ha[k] >= 0) ? (5'h01 << ha[k]) : 5'h00;
      cmp <= (a && ha[k] >= 0) ? 8'h00 : (8'h01 << hc[k]);
      tick(10);
      chk({14'h0000, off, oe}, {14'h0000, k[0], !(m && hm[k] >= 0)});
      cmp <= 8'h00;
      adc <= 5'h00;
      tick(10);
      chk({14'h0000, off, oe}, 16'h0000);
      rdc(4'h0, exp_st(hb[k], m && hm[k] >= 0));
      wr(4'h4, 16'h0001);
      rdc(4'h0, 16'h0000);
    end
    mk <= 8'h00;
    cmp <= 8'h08;
    tick(10);
    chk({15'h0000, off}, 16'h0000);
    cmp <= 8'h00;
    tick(6);
    auto <= 1'b0;
    wr(4'h4, 16'h0001);
    $display("hold fault test done");
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      rails <= 1'b0;
      cmp <= (i == 2) ? 8'h80 : (8'h01 << i);
      tick(10);
      chk({13'h0000, st, oe}, {13'h0000, `NFR_STATE_POR, 1'b1});
      chk({15'h0000, roff}, {15'h0000, i == 2});
      cmp <= 8'h00;
      tick(10);
      chk({14'h0000, st}, {14'h0000, `NFR_STATE_POR});
      rails <= 1'b1;
      tick(6);
      chk({14'h0000, st}, 16'h0000);
      wr(4'h4, 16'h0001);
      rdc(4'h0, 16'h00C0);
      wr(4'h4, 16'h0002);
      rdc(4'h0, 16'h0000);
      chk({15'h0000, oe}, 16'h0000);
    end
    $display("power fault test done");
    give_verdict();
  end
endmodule
